// >>> core/gpio_ab_pkg.sv
// Shared constants, types and decode helpers for the two-port data register block
package gpio_ab_pkg;

    // Port widths and register width
    localparam int unsigned FIRST_WIDTH  = 15;
    localparam int unsigned SECOND_WIDTH = 9;
    localparam int unsigned REG_WIDTH    = 16;
    localparam int unsigned I2C_PINS     = 2;

    // Byte offsets on the register bus
    localparam logic [7:0] OFS_FIRST_DATA  = 8'h00;
    localparam logic [7:0] OFS_SECOND_DATA = 8'h04;
    localparam logic [7:0] OFS_FIRST_FUNC  = 8'h08;
    localparam logic [7:0] OFS_SECOND_FUNC = 8'h0c;
    localparam logic [7:0] OFS_I2C_CTRL    = 8'h10;

    // Field positions inside the shared-pin control register
    localparam int unsigned I2C_FUNC_POS = 0;
    localparam int unsigned I2C_DATA_POS = 8;

    // Values after power-on reset
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [31:0] FUNC_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

    // Two-bit pin function select codes
    typedef enum logic [1:0] {
        FUNC_INPUT     = 2'h0,
        FUNC_OUTPUT    = 2'h1,
        FUNC_RESERVED  = 2'h2,
        FUNC_ALTERNATE = 2'h3
    } func_sel_type;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_type;

    // Pin level is what a read returns
    function automatic logic reads_pin(input logic [1:0] code);
        return (code == FUNC_INPUT) || (code == FUNC_ALTERNATE);
    endfunction

    // Stored bit is what a read returns
    function automatic logic reads_store(input logic [1:0] code);
        return code == FUNC_OUTPUT;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction

endpackage

// >>> core/port_data_slice.sv
// One port: data store, read select, pin drive and weak keeper per pin
`timescale 1ns/1ns
module port_data_slice #(
    parameter int unsigned WIDTH = 15
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wr_en_i,
    input  wire logic [WIDTH-1:0]   wr_data_i,
    input  wire logic [2*WIDTH-1:0] func_sel_i,
    input  wire logic [WIDTH-1:0]   pin_i,
    input  wire logic [WIDTH-1:0]   alt_out_i,
    input  wire logic [WIDTH-1:0]   alt_oe_i,
    output logic      [WIDTH-1:0]   data_o,
    output logic      [WIDTH-1:0]   rd_data_o,
    output logic      [WIDTH-1:0]   pin_o,
    output logic      [WIDTH-1:0]   pin_oe_o,
    output logic      [WIDTH-1:0]   keep_o
);

    logic [WIDTH-1:0]   data_r;
    logic [WIDTH-1:0]   keep_r;
    logic [WIDTH-1:0]   keep_nxt;
    logic [2*WIDTH-1:0] prev_func_r;

    // Store write in every mode; cleared only by power-on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_r <= gpio_ab_pkg::DATA_RESET[WIDTH-1:0];
        end else if (wr_en_i) begin
            data_r <= wr_data_i;
        end
    end

    // Keeper value and previous function code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            keep_r      <= gpio_ab_pkg::DATA_RESET[WIDTH-1:0];
            prev_func_r <= gpio_ab_pkg::FUNC_RESET[2*WIDTH-1:0];
        end else begin
            keep_r      <= keep_nxt;
            prev_func_r <= func_sel_i;
        end
    end

    // Per-pin read select, drive and keeper update
    for (genvar g = 0; g < WIDTH; g++) begin : g_pin
        wire logic [1:0] code = func_sel_i[2*g +: 2];
        wire logic [1:0] prev = prev_func_r[2*g +: 2];
        wire logic       to_in = (prev == gpio_ab_pkg::FUNC_ALTERNATE)
                               && (code == gpio_ab_pkg::FUNC_INPUT);
        wire logic       to_alt = (prev == gpio_ab_pkg::FUNC_INPUT)
                                && (code == gpio_ab_pkg::FUNC_ALTERNATE);
        // Read: pin level, stored bit, or zero when reserved
        assign rd_data_o[g] = gpio_ab_pkg::reads_pin(code)   ? pin_i[g] :
                              gpio_ab_pkg::reads_store(code) ? data_r[g] :
                              1'b0;
        // Drive only in output or alternate mode
        assign pin_o[g] = (code == gpio_ab_pkg::FUNC_OUTPUT)    ? data_r[g] :
                          (code == gpio_ab_pkg::FUNC_ALTERNATE) ? alt_out_i[g] :
                          1'b0;
        assign pin_oe_o[g] = (code == gpio_ab_pkg::FUNC_OUTPUT)
                           | ((code == gpio_ab_pkg::FUNC_ALTERNATE) & alt_oe_i[g]);
        // Keeper follows the driven level, captures on mode change
        assign keep_nxt[g] = to_in       ? data_r[g] :
                             to_alt      ? alt_out_i[g] :
                             pin_oe_o[g] ? pin_o[g] :
                             keep_r[g];
    end

    assign data_o = data_r;
    assign keep_o = keep_r;

endmodule

// >>> core/gpio_ab_data_regs.sv
// Two-port pin data registers with Wishbone slave and shared I2C pins
`timescale 1ns/1ns
module gpio_ab_data_regs #(
    parameter int unsigned FIRST_WIDTH  = gpio_ab_pkg::FIRST_WIDTH,
    parameter int unsigned SECOND_WIDTH = gpio_ab_pkg::SECOND_WIDTH
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    manual_rst_i,
    input  wire gpio_ab_pkg::wb_req_type wb_req_i,
    output logic                         wb_ack_o,
    output logic [31:0]                  wb_dat_o,
    input  wire logic [FIRST_WIDTH-1:0]  first_pin_i,
    output logic      [FIRST_WIDTH-1:0]  first_pin_o,
    output logic      [FIRST_WIDTH-1:0]  first_pin_oe_o,
    output logic      [FIRST_WIDTH-1:0]  first_keep_o,
    input  wire logic [FIRST_WIDTH-1:0]  first_alt_out_i,
    input  wire logic [FIRST_WIDTH-1:0]  first_alt_oe_i,
    input  wire logic [SECOND_WIDTH-1:0] second_pin_i,
    output logic      [SECOND_WIDTH-1:0] second_pin_o,
    output logic      [SECOND_WIDTH-1:0] second_pin_oe_o,
    output logic      [SECOND_WIDTH-1:0] second_keep_o,
    input  wire logic [SECOND_WIDTH-1:0] second_alt_out_i,
    input  wire logic [SECOND_WIDTH-1:0] second_alt_oe_i,
    input  wire logic [1:0]              i2c_pin_i,
    output logic      [1:0]              i2c_pin_o,
    output logic      [1:0]              i2c_pin_oe_o,
    output logic      [1:0]              i2c_open_drain_o,
    input  wire logic [1:0]              i2c_alt_out_i
);

    logic                      ack_r;
    logic [31:0]               rdat_r;
    logic [31:0]               rdat_nxt;
    logic [2*FIRST_WIDTH-1:0]  first_func_r;
    logic [2*SECOND_WIDTH-1:0] second_func_r;
    logic [3:0]                i2c_func_r;
    logic [1:0]                i2c_data_r;
    logic [FIRST_WIDTH-1:0]    first_data;
    logic [FIRST_WIDTH-1:0]    first_rd;
    logic [SECOND_WIDTH-1:0]   second_data;
    logic [SECOND_WIDTH-1:0]   second_rd;
    logic [1:0]                i2c_rd;

    // Bus access decode
    wire logic access     = wb_req_i.cyc & wb_req_i.stb;
    wire logic take       = access & ~ack_r;
    wire logic wr_strobe  = access & wb_req_i.we & ack_r;
    wire logic hit_first  = wb_req_i.adr == gpio_ab_pkg::OFS_FIRST_DATA;
    wire logic hit_second = wb_req_i.adr == gpio_ab_pkg::OFS_SECOND_DATA;
    wire logic hit_ffunc  = wb_req_i.adr == gpio_ab_pkg::OFS_FIRST_FUNC;
    wire logic hit_sfunc  = wb_req_i.adr == gpio_ab_pkg::OFS_SECOND_FUNC;
    wire logic hit_i2c    = wb_req_i.adr == gpio_ab_pkg::OFS_I2C_CTRL;
    wire logic wr_first   = wr_strobe & hit_first;
    wire logic wr_second  = wr_strobe & hit_second;

    // Current register words, reserved bits as zero
    wire logic [31:0] first_word   = 32'(first_data);
    wire logic [31:0] second_word  = 32'(second_data);
    wire logic [31:0] ffunc_word   = 32'(first_func_r);
    wire logic [31:0] sfunc_word   = 32'(second_func_r);
    wire logic [31:0] i2c_word     = (32'(i2c_data_r) << gpio_ab_pkg::I2C_DATA_POS)
                                   | (32'(i2c_func_r) << gpio_ab_pkg::I2C_FUNC_POS);
    wire logic [31:0] i2c_rd_word  = (32'(i2c_rd) << gpio_ab_pkg::I2C_DATA_POS)
                                   | (32'(i2c_func_r) << gpio_ab_pkg::I2C_FUNC_POS);

    // Byte-lane merged write values
    wire logic [31:0] first_wr  = gpio_ab_pkg::lane_merge(first_word, wb_req_i.dat,
                                                          wb_req_i.sel);
    wire logic [31:0] second_wr = gpio_ab_pkg::lane_merge(second_word, wb_req_i.dat,
                                                          wb_req_i.sel);
    wire logic [31:0] ffunc_wr  = gpio_ab_pkg::lane_merge(ffunc_word, wb_req_i.dat,
                                                          wb_req_i.sel);
    wire logic [31:0] sfunc_wr  = gpio_ab_pkg::lane_merge(sfunc_word, wb_req_i.dat,
                                                          wb_req_i.sel);
    wire logic [31:0] i2c_wr    = gpio_ab_pkg::lane_merge(i2c_word, wb_req_i.dat,
                                                          wb_req_i.sel);

    // Read select; unmapped offsets read zero
    assign rdat_nxt = hit_first  ? 32'(first_rd) :
                      hit_second ? 32'(second_rd) :
                      hit_ffunc  ? ffunc_word :
                      hit_sfunc  ? sfunc_word :
                      hit_i2c    ? i2c_rd_word :
                      gpio_ab_pkg::READ_ZERO;

    // Ack one cycle after the request, read data captured with it
    always_ff @(posedge clk_i) begin
        if (rst_i || manual_rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= gpio_ab_pkg::READ_ZERO;
        end else begin
            ack_r  <= take;
            rdat_r <= take ? rdat_nxt : rdat_r;
        end
    end

    // Function select and shared-pin registers, power-on reset only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_func_r  <= gpio_ab_pkg::FUNC_RESET[2*FIRST_WIDTH-1:0];
            second_func_r <= gpio_ab_pkg::FUNC_RESET[2*SECOND_WIDTH-1:0];
            i2c_func_r    <= gpio_ab_pkg::FUNC_RESET[3:0];
            i2c_data_r    <= gpio_ab_pkg::FUNC_RESET[1:0];
        end else if (wr_strobe) begin
            first_func_r  <= hit_ffunc ? ffunc_wr[2*FIRST_WIDTH-1:0] : first_func_r;
            second_func_r <= hit_sfunc ? sfunc_wr[2*SECOND_WIDTH-1:0] : second_func_r;
            i2c_func_r    <= hit_i2c ? i2c_wr[gpio_ab_pkg::I2C_FUNC_POS +: 4] : i2c_func_r;
            i2c_data_r    <= hit_i2c ? i2c_wr[gpio_ab_pkg::I2C_DATA_POS +: 2] : i2c_data_r;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // First port pins; bit 15 never stored
    port_data_slice #(
        .WIDTH (FIRST_WIDTH)
    ) u_first (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (wr_first),
        .wr_data_i  (first_wr[FIRST_WIDTH-1:0]),
        .func_sel_i (first_func_r),
        .pin_i      (first_pin_i),
        .alt_out_i  (first_alt_out_i),
        .alt_oe_i   (first_alt_oe_i),
        .data_o     (first_data),
        .rd_data_o  (first_rd),
        .pin_o      (first_pin_o),
        .pin_oe_o   (first_pin_oe_o),
        .keep_o     (first_keep_o)
    );

    // Second port pins; bits 15 to 9 never stored
    port_data_slice #(
        .WIDTH (SECOND_WIDTH)
    ) u_second (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (wr_second),
        .wr_data_i  (second_wr[SECOND_WIDTH-1:0]),
        .func_sel_i (second_func_r),
        .pin_i      (second_pin_i),
        .alt_out_i  (second_alt_out_i),
        .alt_oe_i   (second_alt_oe_i),
        .data_o     (second_data),
        .rd_data_o  (second_rd),
        .pin_o      (second_pin_o),
        .pin_oe_o   (second_pin_oe_o),
        .keep_o     (second_keep_o)
    );

    // Shared I2C pins: buffer select, no keeper at all
    for (genvar i = 0; i < 2; i++) begin : g_i2c
        wire logic [1:0] code = i2c_func_r[2*i +: 2];
        wire logic       alt  = code == gpio_ab_pkg::FUNC_ALTERNATE;
        wire logic       outm = code == gpio_ab_pkg::FUNC_OUTPUT;
        // Open drain only pulls low in alternate mode
        assign i2c_open_drain_o[i] = alt;
        assign i2c_pin_o[i]        = outm ? i2c_data_r[i] : 1'b0;
        assign i2c_pin_oe_o[i]     = outm | (alt & ~i2c_alt_out_i[i]);
        assign i2c_rd[i] = gpio_ab_pkg::reads_pin(code)   ? i2c_pin_i[i] :
                           gpio_ab_pkg::reads_store(code) ? i2c_data_r[i] :
                           1'b0;
    end

    // Checks on bus answers, pin drive and keeper behaviour
    wire logic [1:0] f0 = first_func_r[1:0];

    property p_ack_one_cycle;
        @(posedge clk_i) disable iff (rst_i || manual_rst_i)
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("ack not a single cycle after request");

    property p_first_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_first && wb_req_i.sel == 4'hf) |=> first_data == $past(wb_req_i.dat[14:0]);
    endproperty
    a_first_write: assert property (p_first_write)
        else $error("first port write not stored");

    property p_first_top_zero;
        @(posedge clk_i) disable iff (rst_i || manual_rst_i)
        (take && hit_first) |=> wb_dat_o[31:15] == 17'h00000;
    endproperty
    a_first_top_zero: assert property (p_first_top_zero)
        else $error("first port reserved bit not zero");

    property p_first_keep_manual;
        @(posedge clk_i) disable iff (rst_i)
        (manual_rst_i && !wr_first) |=> $stable(first_data);
    endproperty
    a_first_keep_manual: assert property (p_first_keep_manual)
        else $error("first port data lost on manual reset");

    property p_read_pin;
        @(posedge clk_i) disable iff (rst_i || manual_rst_i)
        (take && hit_first && (f0 == 2'h0 || f0 == 2'h3))
            |=> wb_dat_o[0] == $past(first_pin_i[0]);
    endproperty
    a_read_pin: assert property (p_read_pin)
        else $error("input or alternate read not pin level");

    property p_input_no_drive;
        @(posedge clk_i) disable iff (rst_i)
        (f0 == 2'h0) |-> !first_pin_oe_o[0];
    endproperty
    a_input_no_drive: assert property (p_input_no_drive)
        else $error("input pin driven");

    property p_out_drive;
        @(posedge clk_i) disable iff (rst_i)
        (f0 == 2'h1) |-> first_pin_oe_o[0] && first_pin_o[0] == first_data[0];
    endproperty
    a_out_drive: assert property (p_out_drive)
        else $error("output pin not driving stored bit");

    property p_out_read;
        @(posedge clk_i) disable iff (rst_i || manual_rst_i)
        (take && hit_first && f0 == 2'h1) |=> wb_dat_o[0] == $past(first_data[0]);
    endproperty
    a_out_read: assert property (p_out_read)
        else $error("output read not stored bit");

    property p_second_top_zero;
        @(posedge clk_i) disable iff (rst_i || manual_rst_i)
        (take && hit_second) |=> wb_dat_o[31:9] == 23'h000000;
    endproperty
    a_second_top_zero: assert property (p_second_top_zero)
        else $error("second port reserved bits not zero");

    property p_second_keep_manual;
        @(posedge clk_i) disable iff (rst_i)
        (manual_rst_i && !wr_second) |=> $stable(second_data);
    endproperty
    a_second_keep_manual: assert property (p_second_keep_manual)
        else $error("second port data lost on manual reset");

    property p_open_drain;
        @(posedge clk_i) disable iff (rst_i)
        (i2c_func_r[1:0] == 2'h3) |-> i2c_open_drain_o[0] && !i2c_pin_o[0]
            && (i2c_pin_oe_o[0] == !i2c_alt_out_i[0]);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("shared pin not open drain in alternate mode");

    property p_keep_to_input;
        @(posedge clk_i) disable iff (rst_i)
        (f0 == 2'h3 ##1 f0 == 2'h0) |=> first_keep_o[0] == $past(first_data[0]);
    endproperty
    a_keep_to_input: assert property (p_keep_to_input)
        else $error("keeper missed data bit on change to input");

    property p_keep_to_alt;
        @(posedge clk_i) disable iff (rst_i)
        (f0 == 2'h0 ##1 f0 == 2'h3) |=> first_keep_o[0] == $past(first_alt_out_i[0]);
    endproperty
    a_keep_to_alt: assert property (p_keep_to_alt)
        else $error("keeper missed alternate value on change");

    property p_reserved;
        @(posedge clk_i) disable iff (rst_i || manual_rst_i)
        (take && hit_first && f0 == 2'h2) |=> !wb_dat_o[0] && !first_pin_oe_o[0];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code read nonzero or drove pin");

    property p_manual_ack_clear;
        @(posedge clk_i) disable iff (rst_i)
        manual_rst_i |=> !wb_ack_o;
    endproperty
    a_manual_ack_clear: assert property (p_manual_ack_clear)
        else $error("ack not cleared by manual reset");

    property p_reset_clear;
        @(posedge clk_i)
        rst_i |=> (first_data == '0) && (second_data == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("port data not cleared by power-on reset");

    property p_second_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_second && wb_req_i.sel == 4'hf) |=> second_data == $past(wb_req_i.dat[8:0]);
    endproperty
    a_second_write: assert property (p_second_write)
        else $error("second port write not stored");

    property p_second_out_drive;
        @(posedge clk_i) disable iff (rst_i)
        (second_func_r[1:0] == 2'h1) |-> second_pin_oe_o[0]
            && second_pin_o[0] == second_data[0];
    endproperty
    a_second_out_drive: assert property (p_second_out_drive)
        else $error("second port output pin not driving stored bit");

    property p_second_in_no_drive;
        @(posedge clk_i) disable iff (rst_i)
        (second_func_r[1:0] == 2'h0) |-> !second_pin_oe_o[0];
    endproperty
    a_second_in_no_drive: assert property (p_second_in_no_drive)
        else $error("second port input pin driven");

    property p_i2c_normal_buffer;
        @(posedge clk_i) disable iff (rst_i)
        (i2c_func_r[1:0] != 2'h3) |-> !i2c_open_drain_o[0];
    endproperty
    a_i2c_normal_buffer: assert property (p_i2c_normal_buffer)
        else $error("shared pin open drain outside alternate mode");

    property p_i2c_in_no_drive;
        @(posedge clk_i) disable iff (rst_i)
        (i2c_func_r[1:0] == 2'h0) |-> !i2c_pin_oe_o[0];
    endproperty
    a_i2c_in_no_drive: assert property (p_i2c_in_no_drive)
        else $error("shared input pin held by the block");

    // Main scenarios
    c_first_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_first);
    c_second_read: cover property (@(posedge clk_i) disable iff (rst_i)
        take && hit_second && !wb_req_i.we);
    c_alt_to_in: cover property (@(posedge clk_i) disable iff (rst_i)
        f0 == 2'h3 ##1 f0 == 2'h0);
    c_i2c_od: cover property (@(posedge clk_i) disable iff (rst_i)
        i2c_open_drain_o[0] && i2c_pin_oe_o[0]);
    c_second_out: cover property (@(posedge clk_i) disable iff (rst_i)
        second_func_r[1:0] == 2'h1 && second_pin_o[0]);

endmodule

// >>> bench/pin_partner.sv
// Behavioural model of the external parties that drive or sense one group of pins
`timescale 1ns/1ns
module pin_partner #(
    parameter int unsigned WIDTH = 15
) (
    input  wire logic [WIDTH-1:0] pin_o_i,
    input  wire logic [WIDTH-1:0] oe_i,
    input  wire logic [WIDTH-1:0] keep_i,
    input  wire logic [WIDTH-1:0] ext_val_i,
    input  wire logic [WIDTH-1:0] ext_en_i,
    output logic      [WIDTH-1:0] level_o
);
    // Wire level: block drive first, then external drive, else keeper or pull level
    assign level_o = (oe_i & pin_o_i)
                   | (~oe_i & ext_en_i & ext_val_i)
                   | (~oe_i & ~ext_en_i & keep_i);
endmodule

// >>> bench/port_a_b_data_registers_tb.sv
// Self-checking bench for the two-port pin data registers
`timescale 1ns/1ns
module port_a_b_data_registers_tb;
    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    manual_rst_i = 1'b0;
    gpio_ab_pkg::wb_req_type wb_req = '0;
    logic                    wb_ack;
    logic [31:0]             wb_dat;
    logic [31:0]             rd;
    logic [14:0]             a_in, a_out, a_oe, a_keep;
    logic [14:0]             a_alt = '0;
    logic [14:0]             a_aoe = '0;
    logic [14:0]             a_ext = '0;
    logic [14:0]             a_en = '0;
    logic [8:0]              b_in, b_out, b_oe, b_keep;
    logic [1:0]              g_in, g_out, g_oe, g_od;
    logic [1:0]              g_alt = '0;
    logic [1:0]              g_pull = 2'h3;
    logic [1:0]              g_ext = '0;
    logic [1:0]              g_en = '0;
    int                      bad_count = 0;
    int                      comparisons = 0;

    // Free-running bench clock, 50 ns period
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    gpio_ab_data_regs dut (.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(manual_rst_i),
        .wb_req_i(wb_req), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat),
        .first_pin_i(a_in), .first_pin_o(a_out), .first_pin_oe_o(a_oe),
        .first_keep_o(a_keep), .first_alt_out_i(a_alt), .first_alt_oe_i(a_aoe),
        .second_pin_i(b_in), .second_pin_o(b_out), .second_pin_oe_o(b_oe),
        .second_keep_o(b_keep), .second_alt_out_i(a_alt[8:0]),
        .second_alt_oe_i(a_aoe[8:0]), .i2c_pin_i(g_in), .i2c_pin_o(g_out),
        .i2c_pin_oe_o(g_oe), .i2c_open_drain_o(g_od), .i2c_alt_out_i(g_alt));

    // Far-side pins; shared pins have no keeper, only a pull resistor
    pin_partner #(.WIDTH(15)) pa (.pin_o_i(a_out), .oe_i(a_oe), .keep_i(a_keep),
        .ext_val_i(a_ext), .ext_en_i(a_en), .level_o(a_in));
    pin_partner #(.WIDTH(9)) pb (.pin_o_i(b_out), .oe_i(b_oe), .keep_i(b_keep),
        .ext_val_i(a_ext[8:0]), .ext_en_i(a_en[8:0]), .level_o(b_in));
    pin_partner #(.WIDTH(2)) pg (.pin_o_i(g_out), .oe_i(g_oe), .keep_i(g_pull),
        .ext_val_i(g_ext), .ext_en_i(g_en), .level_o(g_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Classic single Wishbone cycle; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_dat;
        wb_req <= '0;
        if (n >= 20) begin
            bad_count++;
            complete_run();
        end
    endtask

    task automatic test_output;
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_FUNC, 32'h1555_5555);
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_DATA, 32'hffff_ffff);
        wb(1'b0, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0);
        chk(rd, 32'h0000_7fff);
        chk({17'h0, a_out & a_oe}, 32'h0000_7fff);
        wb(1'b1, gpio_ab_pkg::OFS_SECOND_FUNC, 32'h0001_5555);
        wb(1'b1, gpio_ab_pkg::OFS_SECOND_DATA, 32'hffff_ffff);
        wb(1'b0, gpio_ab_pkg::OFS_SECOND_DATA, 32'h0);
        chk(rd, 32'h0000_01ff);
        chk({23'h0, b_out & b_oe}, 32'h0000_01ff);
        chk({23'h0, b_keep}, 32'h0000_01ff);
        $display("test output done");
    endtask

    task automatic test_retain;
        @(posedge clk_i);
        manual_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        manual_rst_i <= 1'b0;
        wb(1'b0, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0);
        chk(rd, 32'h0000_7fff);
        wb(1'b0, gpio_ab_pkg::OFS_SECOND_DATA, 32'h0);
        chk(rd, 32'h0000_01ff);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({17'h0, a_oe}, 32'h0);
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_FUNC, 32'h1555_5555);
        wb(1'b0, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, gpio_ab_pkg::OFS_SECOND_FUNC, 32'h0001_5555);
        wb(1'b0, gpio_ab_pkg::OFS_SECOND_DATA, 32'h0);
        chk(rd, 32'h0);
        $display("test retain done");
    endtask

    task automatic test_input;
        a_en <= 15'h7fff;
        a_ext <= 15'h2aaa;
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_FUNC, 32'h0);
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0000_1555);
        wb(1'b0, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0);
        chk(rd, 32'h0000_2aaa);
        chk({17'h0, a_oe}, 32'h0);
        $display("test input done");
    endtask

    task automatic test_alt;
        a_en <= '0;
        a_alt <= 15'h1234;
        a_aoe <= 15'h7fff;
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0000_0f0f);
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_FUNC, 32'h3fff_ffff);
        repeat (3) @(posedge clk_i);
        chk({17'h0, a_keep}, 32'h0000_1234);
        wb(1'b0, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0);
        chk(rd, 32'h0000_1234);
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_FUNC, 32'h0);
        repeat (3) @(posedge clk_i);
        chk({17'h0, a_keep}, 32'h0000_0f0f);
        wb(1'b0, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0);
        chk(rd, 32'h0000_0f0f);
        wb(1'b1, gpio_ab_pkg::OFS_FIRST_FUNC, 32'h2aaa_aaaa);
        wb(1'b0, gpio_ab_pkg::OFS_FIRST_DATA, 32'h0);
        chk(rd, 32'h0);
        chk({17'h0, a_oe}, 32'h0);
        $display("test alternate done");
    endtask

    task automatic test_i2c;
        g_alt <= 2'h2;
        wb(1'b1, gpio_ab_pkg::OFS_I2C_CTRL, 32'h0000_000f);
        @(posedge clk_i);
        chk({30'h0, g_od}, 32'h3);
        chk({30'h0, g_in}, 32'h2);
        wb(1'b1, gpio_ab_pkg::OFS_I2C_CTRL, 32'h0000_0105);
        @(posedge clk_i);
        chk({30'h0, g_od}, 32'h0);
        chk({30'h0, g_in}, 32'h1);
        wb(1'b1, gpio_ab_pkg::OFS_I2C_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        wb(1'b0, gpio_ab_pkg::OFS_I2C_CTRL, 32'h0);
        chk(rd & 32'h0000_0300, 32'h0000_0300);
        g_pull <= 2'h0;
        g_en   <= 2'h2;
        g_ext  <= 2'h2;
        wb(1'b0, gpio_ab_pkg::OFS_I2C_CTRL, 32'h0);
        chk(rd & 32'h0000_0300, 32'h0000_0200);
        wb(1'b1, 8'h20, 32'hffff_ffff);
        wb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        $display("test shared pins done");
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        test_output();
        test_retain();
        test_input();
        test_alt();
        test_i2c();
        complete_run();
    end
endmodule
